// ==== hdl/csxe_pkg.sv ====
/*
 * Shared constants for the subtract / swap / exclusive-OR execute slice:
 * opcode codes, status bit positions, reset values, register offsets.
 * Assumes the instruction decoder and the register port both use these codes.
 */
package csxe_pkg;

    // Data path width
    localparam int unsigned CSXE_DATA_W = 8;
    // File address width, addresses 0 to 127
    localparam int unsigned CSXE_FADDR_W = 7;
    // Register port address width
    localparam int unsigned CSXE_RADDR_W = 4;

    // Instruction codes driven by the decoder
    typedef enum logic [3:0] {
        CSXE_OP_NONE   = 4'h0, // No operation
        CSXE_OP_SLEEP  = 4'h1, // Enter sleep
        CSXE_OP_LSUB   = 4'h2, // literal_subtract_op
        CSXE_OP_FSUB   = 4'h3, // file_subtract_op
        CSXE_OP_FSUBB  = 4'h4, // file_subtract_borrow_op
        CSXE_OP_NSWAP  = 4'h5, // nibble_swap_op
        CSXE_OP_DIRLD  = 4'h6, // direction_load_op
        CSXE_OP_LXOR   = 4'h7, // literal_xor_op
        CSXE_OP_FXOR   = 4'h8  // file_xor_op
    } csxe_op_t;

    // Status bit positions
    localparam int unsigned CSXE_ST_CARRY = 0;
    localparam int unsigned CSXE_ST_DC = 1;
    localparam int unsigned CSXE_ST_ZERO = 2;
    localparam int unsigned CSXE_ST_PD = 3;
    localparam int unsigned CSXE_ST_TO = 4;

    // Status reset values
    localparam logic CSXE_RST_CARRY = 1'b0;
    localparam logic CSXE_RST_DC = 1'b0;
    localparam logic CSXE_RST_ZERO = 1'b0;
    localparam logic CSXE_RST_PD = 1'b1;
    localparam logic CSXE_RST_TO = 1'b1;

    // Other reset values
    localparam logic [7:0] CSXE_RST_W = 8'h00;
    localparam logic [7:0] CSXE_RST_DIR = 8'hFF;
    localparam logic [7:0] CSXE_ZERO8 = 8'h00;

    // Direction-load operand codes
    localparam logic [7:0] CSXE_DIR_A_SEL = 8'h05;
    localparam logic [7:0] CSXE_DIR_B_SEL = 8'h06;
    localparam logic [7:0] CSXE_DIR_C_SEL = 8'h07;

    // Register port offsets
    localparam logic [3:0] CSXE_REG_W = 4'h0;
    localparam logic [3:0] CSXE_REG_STATUS = 4'h1;
    localparam logic [3:0] CSXE_REG_DIR_A = 4'h2;
    localparam logic [3:0] CSXE_REG_DIR_B = 4'h3;
    localparam logic [3:0] CSXE_REG_DIR_C = 4'h4;
    localparam logic [3:0] CSXE_REG_WDOG = 4'h5;
    localparam logic [3:0] CSXE_REG_WPRE = 4'h6;

    // Watchdog defaults
    localparam int unsigned CSXE_WDOG_W = 8;
    localparam int unsigned CSXE_WPRE_W = 8;

endpackage : csxe_pkg

// ==== hdl/csxe_sub8.sv ====
/*
 * Two's complement subtractor: minuend + ~subtrahend + carry in.
 * Assumes carry in is 1 for a plain subtract, the carry flag for borrow.
 */
`timescale 1ns/10ps
`default_nettype none

module csxe_sub8 #(
    parameter int unsigned W = 8 // Operand width, at least 4
) (
    input wire logic [W-1:0] min_i, // Minuend
    input wire logic [W-1:0] sub_i, // Subtrahend
    input wire logic cin_i, // 1 means no borrow pending
    output logic [W-1:0] res_o, // Difference
    output logic carry_o, // 1 when no borrow out
    output logic dcarry_o // 1 when no borrow out of low nibble
);

    logic [W:0] full_sum; // Full width sum with carry out
    logic [4:0] low_sum; // Low nibble sum with carry out

    // Adding the inverse keeps one adder for all three subtract forms
    assign full_sum = {1'b0, min_i} + {1'b0, ~sub_i} + {{W{1'b0}}, cin_i};
    assign low_sum = {1'b0, min_i[3:0]} + {1'b0, ~sub_i[3:0]} + {4'h0, cin_i};

    // Split results
    assign res_o = full_sum[W-1:0];
    assign carry_o = full_sum[W];
    assign dcarry_o = low_sum[4];

endmodule // csxe_sub8

`default_nettype wire

// ==== hdl/csxe_exec.sv ====
/*
 * Execute slice for sleep, subtract, nibble swap, direction load and XOR.
 * Holds the working register, status flags, direction registers and a
 * small watchdog counter with prescaler. Assumes the decoder presents one
 * instruction per cycle with the addressed file value already read.
 */
// Operation
// - Sleep clears powerdown, sets timeout only
// - Sleep zeroes watchdog counter and prescaler
// - Literal minus W into W, flags
// - Literal subtract carry: W at most literal
// - File minus W, addresses 0-127, flags
// - File subtract carry: W at most file
// - Borrow subtract removes W and borrow
// - Destination 0 to W, 1 to file
// - Swap nibbles, flags untouched
// - Direction load W into A/B/C
// - Literal XOR into W, zero only
// - File XOR to destination, zero only
`timescale 1ns/10ps
`default_nettype none

module csxe_exec
    import csxe_pkg::*;
#(
    parameter int unsigned WDOG_W = CSXE_WDOG_W, // Watchdog counter width
    parameter int unsigned WPRE_W = CSXE_WPRE_W // Watchdog prescaler width
) (
    input wire logic core_clk_i, // Core clock, 40 MHz
    input wire logic rst_b_i, // Asynchronous reset, active low
    input wire logic instr_valid_i, // Instruction present this cycle
    input wire logic [3:0] instr_op_i, // Instruction code
    input wire logic [7:0] instr_operand_i, // Literal, file address or select
    input wire logic instr_dest_i, // Destination bit
    input wire logic [7:0] file_rdata_i, // Value of addressed file register
    input wire logic [3:0] reg_addr_i, // Register port address
    input wire logic [7:0] reg_wdata_i, // Register port write data
    input wire logic reg_wr_i, // Register write strobe
    input wire logic reg_rd_i, // Register read strobe
    output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
    output logic [7:0] w_o, // Working register
    output logic carry_o, // Carry flag
    output logic digit_carry_flag_o, // Digit carry flag
    output logic zero_o, // Zero flag
    output logic timeout_flag_o, // Time-out flag
    output logic powerdown_flag_o, // Power-down flag
    output logic file_we_o, // File write pulse
    output logic [6:0] file_addr_o, // File write address
    output logic [7:0] file_wdata_o, // File write data
    output logic [7:0] port_a_direction_o, // Port A direction
    output logic [7:0] port_b_direction_o, // Port B direction
    output logic [7:0] port_c_direction_o, // Port C direction
    output logic [WDOG_W-1:0] watchdog_counter_o, // Watchdog count
    output logic sleep_o // One-cycle pulse after sleep executes
);

    // Architectural state
    logic [7:0] w_q; // Working register
    logic carry_q; // Carry
    logic dc_q; // Digit carry
    logic zero_q; // Zero
    logic to_q; // Time-out
    logic pd_q; // Power-down
    logic [7:0] dir_a_q; // Port A direction
    logic [7:0] dir_b_q; // Port B direction
    logic [7:0] dir_c_q; // Port C direction
    logic [WDOG_W-1:0] wdog_q; // Watchdog counter
    logic [WPRE_W-1:0] wpre_q; // Watchdog prescaler
    logic file_we_q; // File write pulse
    logic [6:0] file_addr_q; // File write address
    logic [7:0] file_wdata_q; // File write data
    logic sleep_q; // Sleep pulse
    logic [7:0] rdata_q; // Read data

    // Decode results
    logic [7:0] res_d; // Result of this instruction
    logic w_we_d; // Result goes to W
    logic f_we_d; // Result goes to file
    logic upd_c_d; // Carry updated
    logic upd_dc_d; // Digit carry updated
    logic upd_z_d; // Zero updated
    logic sleep_d; // Sleep executes
    logic dir_a_we_d; // Load port A direction
    logic dir_b_we_d; // Load port B direction
    logic dir_c_we_d; // Load port C direction

    // Subtractor wiring
    logic [7:0] sub_min; // Minuend
    logic sub_cin; // Carry in
    logic [7:0] sub_res; // Difference
    logic sub_c; // Carry out
    logic sub_dc; // Digit carry out

    // Bus write decodes
    logic wr_w; // Write W
    logic wr_st; // Write status

    assign wr_w = reg_wr_i && (reg_addr_i == CSXE_REG_W);
    assign wr_st = reg_wr_i && (reg_addr_i == CSXE_REG_STATUS);

    // Literal for the literal form, file value otherwise
    assign sub_min = (instr_op_i == CSXE_OP_LSUB) ? instr_operand_i : file_rdata_i;
    // Pending borrow is the inverse of carry, so carry feeds straight in
    assign sub_cin = (instr_op_i == CSXE_OP_FSUBB) ? carry_q : 1'b1;

    // Shared subtractor for all three subtract forms
    csxe_sub8 #(
        .W(CSXE_DATA_W)
    ) u_sub (
        .min_i(sub_min),
        .sub_i(w_q),
        .cin_i(sub_cin),
        .res_o(sub_res),
        .carry_o(sub_c),
        .dcarry_o(sub_dc)
    );

    // Instruction decode and result select
    always_comb begin
        res_d = CSXE_ZERO8;
        w_we_d = 1'b0;
        f_we_d = 1'b0;
        upd_c_d = 1'b0;
        upd_dc_d = 1'b0;
        upd_z_d = 1'b0;
        sleep_d = 1'b0;
        dir_a_we_d = 1'b0;
        dir_b_we_d = 1'b0;
        dir_c_we_d = 1'b0;
        if (instr_valid_i) begin
            unique case (instr_op_i)
                CSXE_OP_SLEEP: begin
                    sleep_d = 1'b1;
                end
                CSXE_OP_LSUB: begin
                    // Always lands in W
                    res_d = sub_res;
                    w_we_d = 1'b1;
                    upd_c_d = 1'b1;
                    upd_dc_d = 1'b1;
                    upd_z_d = 1'b1;
                end
                CSXE_OP_FSUB, CSXE_OP_FSUBB: begin
                    res_d = sub_res;
                    w_we_d = !instr_dest_i;
                    f_we_d = instr_dest_i;
                    upd_c_d = 1'b1;
                    upd_dc_d = 1'b1;
                    upd_z_d = 1'b1;
                end
                CSXE_OP_NSWAP: begin
                    // No flag update at all
                    res_d = {file_rdata_i[3:0], file_rdata_i[7:4]};
                    w_we_d = !instr_dest_i;
                    f_we_d = instr_dest_i;
                end
                CSXE_OP_DIRLD: begin
                    // Other selects are ignored
                    dir_a_we_d = (instr_operand_i == CSXE_DIR_A_SEL);
                    dir_b_we_d = (instr_operand_i == CSXE_DIR_B_SEL);
                    dir_c_we_d = (instr_operand_i == CSXE_DIR_C_SEL);
                end
                CSXE_OP_LXOR: begin
                    res_d = w_q ^ instr_operand_i;
                    w_we_d = 1'b1;
                    upd_z_d = 1'b1;
                end
                CSXE_OP_FXOR: begin
                    res_d = w_q ^ file_rdata_i;
                    w_we_d = !instr_dest_i;
                    f_we_d = instr_dest_i;
                    upd_z_d = 1'b1;
                end
                CSXE_OP_NONE: begin
                    // Idle slot
                end
                default: begin
                    // Unknown codes do nothing
                end
            endcase
        end
    end

    // Working register; execution beats a same-cycle bus write
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            w_q <= CSXE_RST_W;
        end else if (w_we_d) begin
            w_q <= res_d;
        end else if (wr_w) begin
            w_q <= reg_wdata_i;
        end
    end

    // Arithmetic flags; hardware update wins over software write
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            carry_q <= CSXE_RST_CARRY;
            dc_q <= CSXE_RST_DC;
            zero_q <= CSXE_RST_ZERO;
        end else begin
            if (upd_c_d) begin
                carry_q <= sub_c;
            end else if (wr_st) begin
                carry_q <= reg_wdata_i[CSXE_ST_CARRY];
            end
            if (upd_dc_d) begin
                dc_q <= sub_dc;
            end else if (wr_st) begin
                dc_q <= reg_wdata_i[CSXE_ST_DC];
            end
            if (upd_z_d) begin
                zero_q <= (res_d == CSXE_ZERO8);
            end else if (wr_st) begin
                zero_q <= reg_wdata_i[CSXE_ST_ZERO];
            end
        end
    end

    // Time-out and power-down; sleep wins over a same-cycle write
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            to_q <= CSXE_RST_TO;
            pd_q <= CSXE_RST_PD;
        end else if (sleep_d) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end else if (wr_st) begin
            to_q <= reg_wdata_i[CSXE_ST_TO];
            pd_q <= reg_wdata_i[CSXE_ST_PD];
        end
    end

    // Direction registers, loaded only by the instruction
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_a_q <= CSXE_RST_DIR;
            dir_b_q <= CSXE_RST_DIR;
            dir_c_q <= CSXE_RST_DIR;
        end else begin
            if (dir_a_we_d) begin
                dir_a_q <= w_q;
            end
            if (dir_b_we_d) begin
                dir_b_q <= w_q;
            end
            if (dir_c_we_d) begin
                dir_c_q <= w_q;
            end
        end
    end

    // Watchdog: prescaler ticks every cycle, counter on prescaler wrap.
    // Counter wraps silently; time-out handling lives outside this slice.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wpre_q <= '0;
            wdog_q <= '0;
        end else if (sleep_d) begin
            wpre_q <= '0;
            wdog_q <= '0;
        end else begin
            wpre_q <= wpre_q + 1'b1;
            if (&wpre_q) begin
                wdog_q <= wdog_q + 1'b1;
            end
        end
    end

    // File write port and sleep pulse, one cycle after execution
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            file_we_q <= 1'b0;
            file_addr_q <= '0;
            file_wdata_q <= CSXE_ZERO8;
            sleep_q <= 1'b0;
        end else begin
            file_we_q <= f_we_d;
            file_addr_q <= instr_operand_i[CSXE_FADDR_W-1:0];
            file_wdata_q <= res_d;
            sleep_q <= sleep_d;
        end
    end

    // Read data; valid only in the cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= CSXE_ZERO8;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                CSXE_REG_W: rdata_q <= w_q;
                CSXE_REG_STATUS: rdata_q <= {3'b000, to_q, pd_q, zero_q, dc_q, carry_q};
                CSXE_REG_DIR_A: rdata_q <= dir_a_q;
                CSXE_REG_DIR_B: rdata_q <= dir_b_q;
                CSXE_REG_DIR_C: rdata_q <= dir_c_q;
                CSXE_REG_WDOG: rdata_q <= 8'(wdog_q);
                CSXE_REG_WPRE: rdata_q <= 8'(wpre_q);
                default: rdata_q <= CSXE_ZERO8; // Unmapped reads zero
            endcase
        end else begin
            rdata_q <= CSXE_ZERO8;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o = rdata_q;
    assign w_o = w_q;
    assign carry_o = carry_q;
    assign digit_carry_flag_o = dc_q;
    assign zero_o = zero_q;
    assign timeout_flag_o = to_q;
    assign powerdown_flag_o = pd_q;
    assign file_we_o = file_we_q;
    assign file_addr_o = file_addr_q;
    assign file_wdata_o = file_wdata_q;
    assign port_a_direction_o = dir_a_q;
    assign port_b_direction_o = dir_b_q;
    assign port_c_direction_o = dir_c_q;
    assign watchdog_counter_o = wdog_q;
    assign sleep_o = sleep_q;

    // Checks; bus writes excluded so flag stability is meaningful
    logic exec_clean; // Instruction without a concurrent bus write
    logic [7:0] dest_seen; // Result wherever it landed
    assign exec_clean = instr_valid_i && !reg_wr_i;
    assign dest_seen = file_we_q ? file_wdata_q : w_q;

    property p_sleep_flags;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        exec_clean && instr_op_i == CSXE_OP_SLEEP |=>
            to_q && !pd_q && $stable(carry_q) && $stable(dc_q) && $stable(zero_q);
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("sleep flag update wrong");

    property p_sleep_wdog;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        instr_valid_i && instr_op_i == CSXE_OP_SLEEP |=> wdog_q == '0 && wpre_q == '0;
    endproperty
    a_sleep_wdog: assert property (p_sleep_wdog)
        else $error("watchdog not cleared by sleep");

    property p_lsub;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        instr_valid_i && instr_op_i == CSXE_OP_LSUB |=>
            w_q == 8'($past(instr_operand_i) - $past(w_q)) && !file_we_q;
    endproperty
    a_lsub: assert property (p_lsub)
        else $error("literal subtract result wrong");

    property p_lsub_flags;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        instr_valid_i && instr_op_i == CSXE_OP_LSUB |=>
            carry_q == ($past(w_q) <= $past(instr_operand_i))
            && dc_q == ($past(w_q[3:0]) <= $past(instr_operand_i[3:0]));
    endproperty
    a_lsub_flags: assert property (p_lsub_flags)
        else $error("literal subtract carry wrong");

    property p_fsub;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        exec_clean && instr_op_i == CSXE_OP_FSUB |=>
            dest_seen == 8'($past(file_rdata_i) - $past(w_q));
    endproperty
    a_fsub: assert property (p_fsub)
        else $error("file subtract result wrong");

    property p_fsub_flags;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        instr_valid_i && instr_op_i == CSXE_OP_FSUB |=>
            carry_q == ($past(w_q) <= $past(file_rdata_i))
            && dc_q == ($past(w_q[3:0]) <= $past(file_rdata_i[3:0]));
    endproperty
    a_fsub_flags: assert property (p_fsub_flags)
        else $error("file subtract carry wrong");

    property p_fsubb;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        exec_clean && instr_op_i == CSXE_OP_FSUBB |=>
            dest_seen == 8'($past(file_rdata_i) - $past(w_q) - {7'h00, !$past(carry_q)});
    endproperty
    a_fsubb: assert property (p_fsubb)
        else $error("borrow subtract result wrong");

    property p_dest;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        exec_clean && instr_op_i == CSXE_OP_FXOR && instr_dest_i |=>
            file_we_q && file_addr_q == $past(instr_operand_i[6:0]) && $stable(w_q)
            ##1 (!file_we_q || $past(instr_valid_i && instr_dest_i));
    endproperty
    a_dest: assert property (p_dest)
        else $error("file destination handling wrong");

    property p_swap;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        exec_clean && instr_op_i == CSXE_OP_NSWAP |=>
            dest_seen == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])}
            && $stable(carry_q) && $stable(dc_q) && $stable(zero_q);
    endproperty
    a_swap: assert property (p_swap)
        else $error("nibble swap wrong");

    property p_dir_b;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        instr_valid_i && instr_op_i == CSXE_OP_DIRLD && instr_operand_i == CSXE_DIR_B_SEL |=>
            dir_b_q == $past(w_q) && $stable(dir_a_q) && $stable(dir_c_q);
    endproperty
    a_dir_b: assert property (p_dir_b)
        else $error("direction load wrong");

    property p_lxor;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        exec_clean && instr_op_i == CSXE_OP_LXOR |=>
            w_q == ($past(w_q) ^ $past(instr_operand_i)) && $stable(carry_q) && $stable(dc_q);
    endproperty
    a_lxor: assert property (p_lxor)
        else $error("literal xor wrong");

    property p_fxor;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        exec_clean && instr_op_i == CSXE_OP_FXOR |=>
            dest_seen == ($past(w_q) ^ $past(file_rdata_i)) && $stable(carry_q);
    endproperty
    a_fxor: assert property (p_fxor)
        else $error("file xor wrong");

    property p_zero;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        instr_valid_i && (instr_op_i == CSXE_OP_LSUB || instr_op_i == CSXE_OP_LXOR) |=>
            zero_q == (w_q == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

endmodule // csxe_exec

`default_nettype wire

// ==== tb/tb_cpu_subtract_swap_xor_execute.sv ====
/* Self-checking bench for the execute slice csxe_exec.
   Assumes csxe_pkg is compiled first; bench drives all ports itself. */
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_subtract_swap_xor_execute;
    import csxe_pkg::*;
    logic clk = 1'b0; // 40 MHz core clock
    logic rst_b = 1'b0; // Reset, active low
    logic iv = 1'b0, idest = 1'b0, rwr = 1'b0, rrd = 1'b0;
    logic [3:0] iop = 4'h0, raddr = 4'h0;
    logic [7:0] iopnd = 8'h00, frd = 8'h00, rwd = 8'h00;
    logic [7:0] rdata, w, fwd, dira, dirb, dirc, wdog;
    logic c, dc, z, to, pd, fwe, slp;
    logic [6:0] faddr;
    int error_cnt = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    // Short prescaler keeps the watchdog moving within a short run
    csxe_exec #(.WPRE_W(2)) u_csxe_exec (.core_clk_i(clk), .rst_b_i(rst_b),
        .instr_valid_i(iv), .instr_op_i(iop), .instr_operand_i(iopnd), .instr_dest_i(idest),
        .file_rdata_i(frd), .reg_addr_i(raddr), .reg_wdata_i(rwd), .reg_wr_i(rwr),
        .reg_rd_i(rrd), .reg_rdata_o(rdata), .w_o(w), .carry_o(c), .digit_carry_flag_o(dc),
        .zero_o(z), .timeout_flag_o(to), .powerdown_flag_o(pd), .file_we_o(fwe),
        .file_addr_o(faddr), .file_wdata_o(fwd), .port_a_direction_o(dira),
        .port_b_direction_o(dirb), .port_c_direction_o(dirc), .watchdog_counter_o(wdog),
        .sleep_o(slp));
    // Status as laid out on the register port
    function automatic logic [7:0] st();
        return {3'b000, to, pd, z, dc, c};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        raddr <= a; rwd <= d; rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        raddr <= a; rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Presets W and status, then issues one instruction; returns settled
    task automatic run(input logic [3:0] op, input logic [7:0] opnd, input logic d,
        input logic [7:0] f, input logic [7:0] w0, input logic [7:0] st0);
        reg_wr(CSXE_REG_W, w0);
        reg_wr(CSXE_REG_STATUS, st0);
        @(posedge clk);
        iv <= 1'b1; iop <= op; iopnd <= opnd; idest <= d; frd <= f;
        @(posedge clk);
        iv <= 1'b0;
        #1;
    endtask
    // Expectation from a 9-bit difference; carry is no borrow out
    task automatic sub_case(input logic [3:0] op, input logic [7:0] f, input logic [7:0] w0,
        input logic cin, input logic d);
        logic lit;
        logic [8:0] full;
        logic [4:0] low;
        lit = (op == CSXE_OP_LSUB);
        full = {1'b0, f} - {1'b0, w0} - {8'h00, ~cin};
        low = {1'b0, f[3:0]} - {1'b0, w0[3:0]} - {4'h0, ~cin};
        // Literal ops get a wrong file value so a mix-up shows
        run(op, lit ? f : 8'h7F, d, lit ? ~f : f, w0, {7'h0C, cin});
        chk(st(), {3'b000, 2'b11, full[7:0] == 8'h00, ~low[4], ~full[8]});
        chk(w, d ? w0 : full[7:0]);
        chk({7'h00, fwe}, {7'h00, d});
        if (d) chk({fwd, 1'b0, faddr}, {full[7:0], 8'h7F});
    endtask
    task automatic t_reset;
        chk({w, st()}, 16'h0018); // reset W and status
        chk({dira, dirb, dirc, wdog}, 32'hFFFF_FF00); // reset directions, watchdog
    endtask
    task automatic t_lsub;
        sub_case(CSXE_OP_LSUB, 8'h05, 8'h05, 1'b1, 1'b0);
        sub_case(CSXE_OP_LSUB, 8'h05, 8'h06, 1'b1, 1'b0);
        sub_case(CSXE_OP_LSUB, 8'h10, 8'h01, 1'b1, 1'b0);
    endtask
    task automatic t_fsub;
        sub_case(CSXE_OP_FSUB, 8'h20, 8'h05, 1'b1, 1'b1);
        sub_case(CSXE_OP_FSUB, 8'h20, 8'h30, 1'b1, 1'b0);
    endtask
    task automatic t_fsubb;
        sub_case(CSXE_OP_FSUBB, 8'h10, 8'h05, 1'b0, 1'b0);
        sub_case(CSXE_OP_FSUBB, 8'h10, 8'h05, 1'b1, 1'b1);
        sub_case(CSXE_OP_FSUBB, 8'h05, 8'h05, 1'b0, 1'b0);
    endtask
    task automatic t_swap;
        run(CSXE_OP_NSWAP, 8'h22, 1'b0, 8'hA5, 8'h00, 8'h07);
        chk({w, st()}, 16'h5A07);
        run(CSXE_OP_NSWAP, 8'h22, 1'b1, 8'h3C, 8'h11, 8'h00);
        chk({fwd, w, st()}, 24'hC3_1100);
    endtask
    task automatic t_dir;
        run(CSXE_OP_DIRLD, 8'h04, 1'b0, 8'h00, 8'h44, 8'h07);
        chk({dira, dirb, dirc}, 24'hFF_FFFF); // operand outside 5..7
        run(CSXE_OP_DIRLD, CSXE_DIR_A_SEL, 1'b0, 8'h00, 8'h15, 8'h07);
        run(CSXE_OP_DIRLD, CSXE_DIR_B_SEL, 1'b1, 8'h00, 8'h26, 8'h07);
        run(CSXE_OP_DIRLD, CSXE_DIR_C_SEL, 1'b0, 8'h00, 8'h37, 8'h07);
        chk({dira, dirb, dirc, st()}, 32'h1526_3707);
        reg_wr(CSXE_REG_DIR_A, 8'h99); // Read-only place, write ignored
        reg_rd(CSXE_REG_DIR_A, 8'h15);
        // Unknown code must leave W, flags, port A direction and file port alone
        run(4'h9, CSXE_DIR_A_SEL, 1'b1, 8'hFF, 8'h44, 8'h07);
        chk({dira, w, st(), 7'h00, fwe}, 32'h1544_0700);
    endtask
    task automatic t_xor;
        run(CSXE_OP_LXOR, 8'h5A, 1'b1, 8'hFF, 8'h5A, 8'h03);
        chk({w, st(), 7'h00, fwe}, 24'h0007_00);
        run(CSXE_OP_LXOR, 8'h0F, 1'b0, 8'h00, 8'h5A, 8'h04);
        chk({w, st()}, 16'h5500);
        run(CSXE_OP_FXOR, 8'h7F, 1'b1, 8'hF0, 8'h0F, 8'h07);
        chk({fwd, w, st(), 7'h00, fwe}, 32'hFF0F_0301);
        run(CSXE_OP_FXOR, 8'h01, 1'b0, 8'h3C, 8'h3C, 8'h03);
        chk({w, st()}, 16'h0007);
    endtask
    // Watchdog has run for many cycles by now, so clearing shows
    task automatic t_sleep;
        chk({7'h00, wdog == 8'h00}, 8'h00); // watchdog has advanced
        run(CSXE_OP_SLEEP, 8'h00, 1'b0, 8'h00, 8'h3C, 8'h07);
        chk({st(), wdog, 7'h00, slp}, 24'h1700_01);
        // Prescaler restarted from zero: one count seen two edges later
        reg_rd(CSXE_REG_WPRE, 8'h01);
        // Cleared prescaler needs four edges before the next count
        @(posedge clk);
        #1 chk(wdog, 8'h00);
        @(posedge clk);
        #1 chk(wdog, 8'h01);
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        t_reset();
        rst_b <= 1'b1;
        reg_rd(CSXE_REG_STATUS, 8'h18); // reset status through the port
        reg_rd(4'hF, 8'h00); // unmapped place reads zero
        t_lsub();
        t_fsub();
        t_fsubb();
        t_swap();
        t_dir();
        t_xor();
        t_sleep();
        finish_test();
    end
endmodule // tb_cpu_subtract_swap_xor_execute
`default_nettype wire
